// ===== design/sic_stop_cond.sv
// stop input conditioner: mode selection, stop latching and motion gating
`timescale 1ns/1ps
`default_nettype none
module sic_stop_cond #(
  parameter bit HAS_MODE16 = 1'b1
) (
  input  wire logic       MCLK_IN,
  input  wire logic       RST_N_IN,
  input  wire logic       STOP_PIN_IN,
  input  wire logic       FUNC_EN_IN,
  input  wire logic       MODE_WR_IN,
  input  wire logic [4:0] MODE_WDATA_IN,
  input  wire logic       STOP_CMD_IN,
  input  wire logic       STOP_CMD_ARG_IN,
  input  wire logic       EXT_LATCH_CLR_IN,
  input  wire logic [2:0] ERR_POLICY_IN,
  input  wire logic       LOOP_ERR_IN,
  input  wire logic       AXES_MOVING_IN,
  output logic [4:0]      MODE_OUT,
  output logic            STOP_STATE_OUT,
  output logic            EXT_LATCH_OUT,
  output logic            HALT_AXES_OUT,
  output logic            SUPPRESS_MOVES_OUT,
  output logic            HAND_INPUT_DEVICE_EN_OUT
);

  logic [4:0] mode_r, mode_nxt;
  logic       sync1_r, sync2_r;
  logic       sync1_nxt, sync2_nxt;
  logic       latch_r, latch_nxt;
  logic       ext_latch_r, ext_latch_nxt;
  logic       halt_r, halt_nxt;
  logic       hid_off_r, hid_off_nxt;
  logic       armed_r, armed_nxt;
  logic       force_r, force_nxt;

  logic mode_ok, is_lat, is_cmp, is_hid, is_hidonly, active, stop_cond, pending;

  function automatic logic valid_mode(input logic [4:0] m);
    valid_mode = (m <= sic_pkg::MODE_LAT_HI)
      || (m >= sic_pkg::MODE_CMP_FIRST && m <= sic_pkg::MODE_CMP_LAST)
      || (hand_mode_ok(m));
  endfunction : valid_mode

  function automatic logic hand_mode_ok(input logic [4:0] m);
    hand_mode_ok = HAS_MODE16 && (m == sic_pkg::MODE_HID_LO || m == sic_pkg::MODE_HID_HI);
  endfunction : hand_mode_ok

  always_comb
  begin
    is_hidonly = (mode_r == sic_pkg::MODE_HID_LO) || (mode_r == sic_pkg::MODE_HID_HI);
    is_lat     = !is_hidonly && mode_r[sic_pkg::LAT_BIT];
    is_cmp     = !is_hidonly && mode_r[sic_pkg::CMP_BIT];
    is_hid     = is_hidonly || mode_r[sic_pkg::HID_BIT] || is_lat;
    // polarity bit 0: 0 = active low, 1 = active high; func select 0 masks input
    active     = FUNC_EN_IN && (sync2_r == mode_r[sic_pkg::POL_BIT]);
    mode_ok    = valid_mode(MODE_WDATA_IN);
  end

  always_comb
  begin
    sync1_nxt     = STOP_PIN_IN;
    sync2_nxt     = sync1_r;
    mode_nxt      = mode_r;
    latch_nxt     = latch_r;
    ext_latch_nxt = ext_latch_r;
    force_nxt     = 1'b0;
    armed_nxt     = armed_r;
    if (MODE_WR_IN && mode_ok)
      mode_nxt = MODE_WDATA_IN;
    if (ERR_POLICY_IN == sic_pkg::ERR_POLICY_LATCH && LOOP_ERR_IN && !is_hidonly)
      mode_nxt = mode_r | sic_pkg::MODE_LATCH_BIT;
    // completing modes: armed while input held through the running move
    pending = is_cmp && active && !is_hidonly;
    if (!pending)
      armed_nxt = 1'b0;
    else if (AXES_MOVING_IN)
      armed_nxt = 1'b1;
    // stop takes effect: immediate modes on input, completing modes once motion is done
    stop_cond = active && !is_hidonly && (!is_cmp || !AXES_MOVING_IN);
    if (STOP_CMD_IN && is_lat && !STOP_CMD_ARG_IN)
      latch_nxt = 1'b0;
    if (STOP_CMD_IN && is_lat && STOP_CMD_ARG_IN)
    begin
      latch_nxt = 1'b1;
      force_nxt = 1'b1;
    end
    // set wins over the release arriving in the same cycle
    if (is_lat && stop_cond)
      latch_nxt = 1'b1;
    if (!is_lat)
      latch_nxt = 1'b0;
    if (EXT_LATCH_CLR_IN)
      ext_latch_nxt = 1'b0;
    if (stop_cond)
      ext_latch_nxt = 1'b1;
    halt_nxt    = is_lat ? latch_nxt : stop_cond;
    hid_off_nxt = (is_lat && latch_nxt) || (is_hidonly && active) || (!is_lat && is_hid && stop_cond);
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (!RST_N_IN)
    begin
      mode_r      <= sic_pkg::MODE_RESET;
      sync1_r     <= 1'b0;
      sync2_r     <= 1'b0;
      latch_r     <= 1'b0;
      ext_latch_r <= 1'b0;
      halt_r      <= 1'b0;
      hid_off_r   <= 1'b0;
      armed_r     <= 1'b0;
      force_r     <= 1'b0;
    end
    else
    begin
      mode_r      <= mode_nxt;
      sync1_r     <= sync1_nxt;
      sync2_r     <= sync2_nxt;
      latch_r     <= latch_nxt;
      ext_latch_r <= ext_latch_nxt;
      halt_r      <= halt_nxt;
      hid_off_r   <= hid_off_nxt;
      armed_r     <= armed_nxt;
      force_r     <= force_nxt;
    end
  end

  assign MODE_OUT                 = mode_r;
  assign STOP_STATE_OUT           = halt_r;
  assign EXT_LATCH_OUT            = ext_latch_r;
  // halting also blocks new moves; a latched stop keeps them blocked till release
  assign HALT_AXES_OUT            = halt_r;
  assign SUPPRESS_MOVES_OUT       = halt_r;
  assign HAND_INPUT_DEVICE_EN_OUT = !hid_off_r;

  property p_reject_bad_mode;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
    (MODE_WR_IN && !mode_ok && !(LOOP_ERR_IN && ERR_POLICY_IN == sic_pkg::ERR_POLICY_LATCH))
      |=> $stable(MODE_OUT);
  endproperty
  a_reject_bad_mode: assert property (p_reject_bad_mode) else $error("invalid mode accepted");

  property p_force_immediate;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
    (STOP_CMD_IN && STOP_CMD_ARG_IN && is_lat && !MODE_WR_IN && !LOOP_ERR_IN) |=> HALT_AXES_OUT;
  endproperty
  a_force_immediate: assert property (p_force_immediate) else $error("forced stop not applied");

  property p_latch_holds;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
    (HALT_AXES_OUT && is_lat && !STOP_CMD_IN && !MODE_WR_IN) |=> HALT_AXES_OUT;
  endproperty
  a_latch_holds: assert property (p_latch_holds) else $error("latched stop dropped");

  property p_release;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
    (STOP_CMD_IN && !STOP_CMD_ARG_IN && is_lat && !active && !MODE_WR_IN && !LOOP_ERR_IN) |=> !HALT_AXES_OUT;
  endproperty
  a_release: assert property (p_release) else $error("release ignored");

  property p_level_hid_kept;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
    (mode_r == sic_pkg::MODE_LVL_LO || mode_r == sic_pkg::MODE_LVL_HI) && $stable(mode_r)
      |-> HAND_INPUT_DEVICE_EN_OUT;
  endproperty
  a_level_hid_kept: assert property (p_level_hid_kept) else $error("hand input lost in mode 0/1");

  property p_hid_only_no_halt;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
    (is_hidonly && $past(is_hidonly)) |-> !HALT_AXES_OUT;
  endproperty
  a_hid_only_no_halt: assert property (p_hid_only_no_halt) else $error("axes halted in hand-only mode");

  property p_func_off;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
    (!FUNC_EN_IN && !is_lat) [*2] |-> !HALT_AXES_OUT;
  endproperty
  a_func_off: assert property (p_func_off) else $error("disabled input halted axes");

  property p_no_halt_while_moving;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
    (is_cmp && !is_lat && AXES_MOVING_IN) |=> !HALT_AXES_OUT;
  endproperty
  a_no_halt_while_moving: assert property (p_no_halt_while_moving) else $error("running move not completed");

  property p_err_escalate;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
    (LOOP_ERR_IN && ERR_POLICY_IN == sic_pkg::ERR_POLICY_LATCH && !is_hidonly) |=> MODE_OUT[sic_pkg::LAT_BIT];
  endproperty
  a_err_escalate: assert property (p_err_escalate) else $error("mode not escalated");

  property p_ext_latch;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
    (stop_cond) |=> EXT_LATCH_OUT;
  endproperty
  a_ext_latch: assert property (p_ext_latch) else $error("input stop not recorded");

  // a forced stop must show on the halt output in the very cycle it is registered
  property p_force_seen;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
    force_r |-> HALT_AXES_OUT;
  endproperty
  a_force_seen: assert property (p_force_seen) else $error("forced stop not on halt");

  // arming happens only while axes travel, so no halt may start with it
  property p_armed_no_halt;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
    ($rose(armed_r) && !$past(is_lat)) |-> !HALT_AXES_OUT;
  endproperty
  a_armed_no_halt: assert property (p_armed_no_halt) else $error("halt during running move");

endmodule : sic_stop_cond
`default_nettype wire

// ===== design/sic_pkg.sv
// package of constants for the stop input conditioner
package sic_pkg;
  localparam int          MODE_W          = 5;
  localparam logic [4:0]  MODE_RESET      = 5'h00;
  localparam logic [4:0]  MODE_LATCH_BIT  = 5'h04;
  localparam logic [4:0]  MODE_LVL_LO     = 5'h00;
  localparam logic [4:0]  MODE_LVL_HI     = 5'h01;
  localparam logic [4:0]  MODE_LVLH_LO    = 5'h02;
  localparam logic [4:0]  MODE_LVLH_HI    = 5'h03;
  localparam logic [4:0]  MODE_LAT_LO     = 5'h04;
  localparam logic [4:0]  MODE_LAT_HI     = 5'h05;
  localparam logic [4:0]  MODE_CMP_FIRST  = 5'h08;
  localparam logic [4:0]  MODE_CMP_LAST   = 5'h0d;
  localparam logic [4:0]  MODE_HID_LO     = 5'h10;
  localparam logic [4:0]  MODE_HID_HI     = 5'h11;
  localparam int          POL_BIT         = 0;
  localparam int          HID_BIT         = 1;
  localparam int          LAT_BIT         = 2;
  localparam int          CMP_BIT         = 3;
  localparam logic [2:0]  ERR_POLICY_LATCH = 3'h4;
  localparam int          CLK_MHZ         = 40;
  localparam int          MIN_ASSERT_US   = 50;
  localparam int          MIN_ASSERT_CYC  = MIN_ASSERT_US * CLK_MHZ;
endpackage : sic_pkg

// ===== tb/sic_stop_src.sv
// model of the external equipment driving the stop pin
`timescale 1ns/1ps
`default_nettype none
module sic_stop_src #(
  parameter int HOLD_CYC = 2000
) (
  input  wire logic clk_in,
  input  wire logic req_in,
  input  wire logic act_hi_in,
  output logic      pin_out
);
  int cnt_r = 0;
  // a short request is stretched to the minimum hold time
  always_ff @(posedge clk_in)
    if (req_in)
      cnt_r <= HOLD_CYC;
    else if (cnt_r > 0)
      cnt_r <= cnt_r - 1;
  // idle is driven to the inactive level, not left to the pull-up
  assign pin_out = (req_in || cnt_r > 0) ? act_hi_in : !act_hi_in;
endmodule : sic_stop_src
`default_nettype wire

// ===== tb/sic_stop_cond_tb.sv
// self-checking bench for the stop input conditioner
`timescale 1ns/1ps
`default_nettype none
module sic_stop_cond_tb;
  logic       clk = 0, rst_n = 0, req = 0, pol = 0, fen = 0, wr = 0, cmd = 0, arg = 0, xclr = 0, lerr = 0, mov = 0;
  logic [4:0] wd = 0, m, em = 0, mode;
  logic [2:0] epol = 0;
  logic       pin, st, xl, halt, supp, hen;
  int         mismatches = 0, check_count = 0, cyc = 0;
  sic_stop_src u_sic_stop_src (.clk_in(clk), .req_in(req), .act_hi_in(pol), .pin_out(pin));
  sic_stop_cond u_sic_stop_cond (.MCLK_IN(clk), .RST_N_IN(rst_n), .STOP_PIN_IN(pin), .FUNC_EN_IN(fen),
    .MODE_WR_IN(wr), .MODE_WDATA_IN(wd), .STOP_CMD_IN(cmd), .STOP_CMD_ARG_IN(arg), .EXT_LATCH_CLR_IN(xclr),
    .ERR_POLICY_IN(epol), .LOOP_ERR_IN(lerr), .AXES_MOVING_IN(mov), .MODE_OUT(mode), .STOP_STATE_OUT(st),
    .EXT_LATCH_OUT(xl), .HALT_AXES_OUT(halt), .SUPPRESS_MOVES_OUT(supp), .HAND_INPUT_DEVICE_EN_OUT(hen));
  initial
    forever #12.5 clk = ~clk;
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      mismatches++;
      test_done();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : step
  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrm(input logic [4:0] v);
    fen = 0;
    wr = 1;
    wd = v;
    step(1);
    wr = 0;
    step(3);
    fen = 1;
  endtask : wrm
  task automatic scmd(input logic a);
    cmd = 1;
    arg = a;
    step(1);
    cmd = 0;
    step(2);
  endtask : scmd
  task automatic pulse(input int n);
    req = 1;
    step(1);
    req = 0;
    step(n);
  endtask : pulse
  function automatic logic ok_mode(input logic [4:0] v);
    return v < 5'h06 || (v > 5'h07 && v < 5'h0e) || v == 5'h10 || v == 5'h11;
  endfunction : ok_mode
  initial
  begin
    void'($urandom(32'h67198b72));
    step(16);
    rst_n = 1;
    step(1);
    chk(mode, 5'h00);
    chk(hen, 5'h01);
    for (int i = 0; i < 40; i++)
    begin
      // corners 4 to 11 cover the unavailable 6 and 7
      m = (i < 8) ? 5'(i + 4) : 5'($urandom);
      em = ok_mode(m) ? m : em;
      wrm(m);
      chk(mode, em);
    end
    for (int v = 0; v < 18; v++)
    begin
      m = 5'(v);
      if (ok_mode(m))
      begin
        pol = m[0];
        wrm(m);
        chk(mode, m);
        pulse(10);
        chk(halt, 5'(m < 5'h10));
        chk(hen, 5'(!(m[1] | m[2] | m[4])));
        step(2000);
        chk(halt, 5'(m[2] & !m[4]));
        if (m < 5'h10)
          chk(xl, 5'h01);
        xclr = 1;
        step(1);
        xclr = 0;
        step(1);
        chk(xl, 5'h00);
        scmd(0);
        chk(st, 5'h00);
      end
    end
    pol = 0;
    mov = 1;
    wrm(5'h0c);
    pulse(2010);
    mov = 0;
    step(5);
    chk(halt, 5'h00);
    mov = 1;
    scmd(1);
    chk(halt, 5'h01);
    chk(supp, 5'h01);
    mov = 0;
    scmd(0);
    chk(halt, 5'h00);
    wrm(5'h00);
    scmd(1);
    chk(halt, 5'h00);
    wrm(5'h04);
    scmd(1);
    chk(st, 5'h01);
    scmd(0);
    chk(st, 5'h00);
    pol = 1;
    wrm(5'h03);
    fen = 0;
    pulse(10);
    chk(halt, 5'h00);
    step(2000);
    pol = 0;
    wrm(5'h00);
    epol = 3'h4;
    lerr = 1;
    step(1);
    lerr = 0;
    step(1);
    chk(mode, 5'h04);
    test_done();
  end
endmodule : sic_stop_cond_tb
`default_nettype wire
